// >>> logic/servo_pkg.sv
// package: constants, register map and types for the servo position loop
package servo_pkg;
    localparam int unsigned clk_hz = 40000000;
    localparam int unsigned period_us_default = 1000;
    localparam int unsigned cycles_per_us = clk_hz / 1000000;
    localparam logic [31:0] period_cycles_default = 32'(period_us_default * cycles_per_us);
    localparam int unsigned gain_frac = 8;
    localparam int unsigned out_w = 16;
    localparam logic signed [15:0] full_scale = 16'sh7fff;
    localparam logic signed [15:0] neg_full_scale = -16'sh7fff;
    localparam logic [6:0] pct_full = 7'h64;
    localparam logic [6:0] fixed_pct_max = 7'h64;
    // register byte offsets
    localparam logic [7:0] off_ctrl = 8'h00;
    localparam logic [7:0] off_period = 8'h04;
    localparam logic [7:0] off_prop_gain = 8'h08;
    localparam logic [7:0] off_vel_gain = 8'h0c;
    localparam logic [7:0] off_deriv_gain = 8'h10;
    localparam logic [7:0] off_int_gain = 8'h14;
    localparam logic [7:0] off_icap = 8'h18;
    localparam logic [7:0] off_kvff = 8'h1c;
    localparam logic [7:0] off_kacc = 8'h20;
    localparam logic [7:0] off_demand_pos = 8'h24;
    localparam logic [7:0] off_cmd = 8'h28;
    localparam logic [7:0] off_status = 8'h2c;
    localparam logic [7:0] off_output = 8'h30;
    localparam logic [7:0] off_ferr = 8'h34;
    // cmd register fields
    localparam int unsigned cmd_op_lsb = 8;
    localparam int unsigned cmd_axis_lsb = 16;
    localparam logic [1:0] op_fixed = 2'h1;
    localparam logic [1:0] op_halt = 2'h2;
    localparam logic [1:0] op_servo = 2'h3;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    typedef enum logic [1:0] {policy_never, policy_always, policy_smart} integral_policy_t;
    typedef enum logic [1:0] {mode_halt, mode_fixed, mode_servo} axis_mode_t;
    typedef struct packed {
        logic signed [15:0] prop_gain;
        logic signed [15:0] vel_feedback_gain;
        logic signed [15:0] deriv_gain;
        logic signed [15:0] integral_gain;
        logic [6:0] integral_cap;
        integral_policy_t integral_policy;
        logic signed [15:0] vel_feedforward_gain;
        logic signed [15:0] accel_feedforward_gain;
    } gains_t;
    typedef struct packed {
        logic signed [31:0] demand_pos;
        logic signed [31:0] measured_pos;
    } positions_t;
endpackage

// >>> logic/servo_axis_calc.sv
// one axis: pid with feedforward, evaluated on each servo tick
`timescale 1ns/1ps
module servo_axis_calc
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // control
    input wire logic tick_in,
    input wire servo_pkg::axis_mode_t mode_in,
    input wire logic signed [7:0] fixed_pct_in,
    input wire servo_pkg::gains_t gains_in,
    input wire servo_pkg::positions_t pos_in,
    // results
    output logic signed [15:0] demand_out,
    output logic signed [31:0] ferr_out
);
    import servo_pkg::*;

    typedef struct packed {
        logic signed [31:0] prev_meas;
        logic signed [31:0] prev_dem;
        logic signed [31:0] prev_dvel;
        logic signed [31:0] prev_err;
        logic signed [47:0] integ;
        logic signed [31:0] ferr;
        logic signed [15:0] demand;
    } calc_state_t;

    calc_state_t state, next_state;

    function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
        if (v > 64'(full_scale))
            sat16 = full_scale;
        else if (v < 64'(neg_full_scale))
            sat16 = neg_full_scale;
        else
            sat16 = v[15:0];
    endfunction

    always_comb
    begin
        logic signed [31:0] err;
        logic signed [31:0] mvel;
        logic signed [31:0] dvel;
        logic signed [31:0] dacc;
        logic signed [63:0] p_term;
        logic signed [63:0] i_term;
        logic signed [63:0] i_lim;
        logic signed [63:0] sum;
        logic signed [47:0] next_integ;
        logic use_int;
        err = '0;
        mvel = '0;
        dvel = '0;
        dacc = '0;
        p_term = '0;
        i_term = '0;
        i_lim = '0;
        sum = '0;
        next_integ = '0;
        use_int = 1'b0;
        next_state = state;
        if (tick_in)
        begin
            err = pos_in.demand_pos - pos_in.measured_pos;
            mvel = pos_in.measured_pos - state.prev_meas;
            dvel = pos_in.demand_pos - state.prev_dem;
            dacc = dvel - state.prev_dvel;
            // smart: integrate only while demanded velocity is steady
            unique case (gains_in.integral_policy)
                policy_always: use_int = 1'b1;
                policy_smart: use_int = (dacc == 0);
                default: use_int = 1'b0;
            endcase
            next_integ = use_int ? state.integ + 48'(err) : '0;
            p_term = 64'(gains_in.prop_gain) * 64'(err);
            p_term = p_term - 64'(gains_in.vel_feedback_gain) * 64'(mvel);
            // derivative on error: equals vel feedback plus vel feedforward when both vel gains match
            p_term = p_term + 64'(gains_in.deriv_gain) * 64'(err - state.prev_err);
            p_term = p_term + 64'(gains_in.vel_feedforward_gain) * 64'(dvel);
            // per-tick count delta: tiny accelerations quantise to zero
            p_term = p_term + 64'(gains_in.accel_feedforward_gain) * 64'(dacc);
            i_term = 64'(gains_in.integral_gain) * 64'(next_integ);
            i_lim = (64'(full_scale) * 64'(gains_in.integral_cap)) / 64'(pct_full);
            i_lim = i_lim <<< gain_frac;
            if (i_term > i_lim)
                i_term = i_lim;
            else if (i_term < -i_lim)
                i_term = -i_lim;
            sum = (p_term + i_term) >>> gain_frac;
            next_state.prev_meas = pos_in.measured_pos;
            next_state.prev_dem = pos_in.demand_pos;
            next_state.prev_dvel = dvel;
            next_state.prev_err = err;
            next_state.ferr = err;
            unique case (mode_in)
                mode_servo:
                begin
                    next_state.integ = next_integ;
                    next_state.demand = sat16(sum);
                end
                mode_fixed:
                begin
                    next_state.integ = '0;
                    // percent of full scale, sign kept: 5 -> 0.5 V of 10 V
                    // divisor kept signed so a negative percent divides as signed
                    next_state.demand = sat16((64'(full_scale) * 64'(fixed_pct_in)) / 64'(int'(pct_full)));
                end
                default:
                begin
                    next_state.integ = '0;
                    next_state.demand = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            state <= '0;
        else
            state <= next_state;
    end

    assign demand_out = state.demand;
    assign ferr_out = state.ferr;

    halt_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
        tick_in && mode_in == mode_halt |=> demand_out == 16'sh0000)
        else $error("halted axis output not zero");
    fixed_level_a: assert property (@(posedge clk_in) disable iff (reset_in)
        tick_in && mode_in == mode_fixed && fixed_pct_in == 8'sh05 |=> demand_out == 16'sh0666)
        else $error("fixed +5 percent wrong level");
    fixed_neg_a: assert property (@(posedge clk_in) disable iff (reset_in)
        tick_in && mode_in == mode_fixed && fixed_pct_in == -8'sh05 |=> demand_out == -16'sh0666)
        else $error("fixed -5 percent wrong level");
    output_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !tick_in |=> $stable(demand_out))
        else $error("demand changed without tick");
    ferr_calc_a: assert property (@(posedge clk_in) disable iff (reset_in)
        tick_in |=> ferr_out == $past(pos_in.demand_pos) - $past(pos_in.measured_pos))
        else $error("following error mismatch");
    output_bound_a: assert property (@(posedge clk_in) disable iff (reset_in)
        demand_out >= neg_full_scale && demand_out <= full_scale)
        else $error("demand beyond full scale");
endmodule

// >>> logic/servo_position_loop.sv
// servo position loop top: axi4-lite registers, tick timer, axis lanes
// How it works
// - fixed-demand axis number picks output channel
// - plus five percent gives 0.5 V
// - negative percent gives matching negative output
// - halt drives that channel to zero
// - compute once per settable loop period
// - following error is demanded minus measured
// - proportional term is error times gain
// - velocity feedback opposes measured motor speed
// - integral accumulates error, scaled by gain
// - integral clamped to percent of full scale
// - integral policy never, always or smart
// - derivative term damps like velocity feedback
// - velocity feedforward from demanded speed only
// - acceleration feedforward from demanded acceleration
`timescale 1ns/1ps
module servo_position_loop
#(
    parameter int unsigned axes = 4,
    parameter logic [31:0] period_default = servo_pkg::period_cycles_default
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // encoder positions, one 32-bit word per axis, from another clock
    input wire logic [axes*32-1:0] measured_pos_in,
    // demand outputs to the dac, one signed 16-bit word per axis
    output logic [axes*16-1:0] axis_output_out,
    output logic servo_tick_out
);
    import servo_pkg::*;

    localparam int unsigned ax_w = $clog2(axes) > 0 ? $clog2(axes) : 1;

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] period;
        logic [31:0] count;
        logic tick;
        logic [ax_w-1:0] sel_axis;
        gains_t [axes-1:0] gains;
        logic [axes-1:0][31:0] demand_pos;
        axis_mode_t [axes-1:0] mode;
        logic [axes-1:0][7:0] fixed_pct;
        logic [axes*32-1:0] meas_s1;
        logic [axes*32-1:0] meas_s2;
        logic [axes*32-1:0] meas_s3;
        logic [axes*32-1:0] meas_hold;
    } top_state_t;

    top_state_t state, next_state;
    logic [axes-1:0][15:0] demand;
    logic [axes-1:0][31:0] ferr;

    // encoder words cross bit by bit; a word is taken only once it has held still
    genvar g;
    generate
        for (g = 0; g < axes; g++)
        begin : lane
            servo_axis_calc u_calc
            (
                .clk_in(clk_in),
                .reset_in(reset_in),
                .tick_in(state.tick),
                .mode_in(state.mode[g]),
                .fixed_pct_in(state.fixed_pct[g]),
                .gains_in(state.gains[g]),
                .pos_in({state.demand_pos[g], state.meas_hold[g*32 +: 32]}),
                .demand_out(demand[g]),
                .ferr_out(ferr[g])
            );
            assign axis_output_out[g*16 +: 16] = demand[g];
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction

    always_comb
    begin
        logic [31:0] v;
        logic [ax_w-1:0] a;
        logic ok;
        logic [ax_w-1:0] c;
        v = '0;
        a = state.sel_axis;
        ok = 1'b1;
        c = '0;
        next_state = state;
        next_state.meas_s1 = measured_pos_in;
        next_state.meas_s2 = state.meas_s1;
        next_state.meas_s3 = state.meas_s2;
        // bits of one word may resolve in different cycles; an encoder moving every cycle is never taken
        for (int i = 0; i < axes; i++)
            if (state.meas_s2[i*32 +: 32] == state.meas_s3[i*32 +: 32])
                next_state.meas_hold[i*32 +: 32] = state.meas_s2[i*32 +: 32];
        // loop period timer; zero period treated as one cycle
        next_state.tick = 1'b0;
        if (state.count + 32'h1 >= state.period)
        begin
            next_state.count = '0;
            next_state.tick = 1'b1;
        end
        else
            next_state.count = state.count + 32'h1;
        if (awvalid && !state.aw_held)
        begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = awaddr;
        end
        if (wvalid && !state.w_held)
        begin
            next_state.w_held = 1'b1;
            next_state.w_data = wdata;
            next_state.w_strb = wstrb;
        end
        if (state.aw_held && state.w_held && !state.bvalid)
        begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            unique case (state.aw_addr)
                off_ctrl: v = merge(32'(state.sel_axis), state.w_data, state.w_strb);
                off_period: v = merge(state.period, state.w_data, state.w_strb);
                off_prop_gain: v = merge(32'(state.gains[a].prop_gain), state.w_data, state.w_strb);
                off_vel_gain: v = merge(32'(state.gains[a].vel_feedback_gain), state.w_data, state.w_strb);
                off_deriv_gain: v = merge(32'(state.gains[a].deriv_gain), state.w_data, state.w_strb);
                off_int_gain: v = merge(32'(state.gains[a].integral_gain), state.w_data, state.w_strb);
                off_icap: v = merge({23'h0, state.gains[a].integral_policy, state.gains[a].integral_cap},
                    state.w_data, state.w_strb);
                off_kvff: v = merge(32'(state.gains[a].vel_feedforward_gain), state.w_data, state.w_strb);
                off_kacc: v = merge(32'(state.gains[a].accel_feedforward_gain), state.w_data, state.w_strb);
                off_demand_pos: v = merge(state.demand_pos[a], state.w_data, state.w_strb);
                off_cmd: v = state.w_data;
                default: ok = 1'b0;
            endcase
            next_state.bresp = ok ? resp_okay : resp_slverr;
            unique case (state.aw_addr)
                off_ctrl: next_state.sel_axis = v[ax_w-1:0];
                off_period: next_state.period = v;
                off_prop_gain: next_state.gains[a].prop_gain = v[15:0];
                off_vel_gain: next_state.gains[a].vel_feedback_gain = v[15:0];
                off_deriv_gain: next_state.gains[a].deriv_gain = v[15:0];
                off_int_gain: next_state.gains[a].integral_gain = v[15:0];
                off_icap:
                begin
                    next_state.gains[a].integral_cap = (v[6:0] > pct_full) ? pct_full : v[6:0];
                    next_state.gains[a].integral_policy = integral_policy_t'(v[8:7]);
                end
                off_kvff: next_state.gains[a].vel_feedforward_gain = v[15:0];
                off_kacc: next_state.gains[a].accel_feedforward_gain = v[15:0];
                off_demand_pos: next_state.demand_pos[a] = v;
                off_cmd:
                begin
                    // command axis field names the channel that is driven
                    // own index so a read in the same cycle still uses the selected axis
                    c = v[cmd_axis_lsb +: ax_w];
                    unique case (v[cmd_op_lsb +: 2])
                        op_fixed:
                        begin
                            next_state.mode[c] = mode_fixed;
                            next_state.fixed_pct[c] = v[7:0];
                        end
                        op_halt: next_state.mode[c] = mode_halt;
                        op_servo: next_state.mode[c] = mode_servo;
                        default: next_state.bresp = resp_slverr;
                    endcase
                end
                default: ;
            endcase
        end
        if (state.bvalid && bready)
            next_state.bvalid = 1'b0;
        if (arvalid && !state.rvalid)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp = resp_okay;
            unique case (araddr)
                off_ctrl: next_state.rdata = 32'(state.sel_axis);
                off_period: next_state.rdata = state.period;
                off_prop_gain: next_state.rdata = 32'(state.gains[a].prop_gain);
                off_vel_gain: next_state.rdata = 32'(state.gains[a].vel_feedback_gain);
                off_deriv_gain: next_state.rdata = 32'(state.gains[a].deriv_gain);
                off_int_gain: next_state.rdata = 32'(state.gains[a].integral_gain);
                off_icap: next_state.rdata = {23'h0, state.gains[a].integral_policy, state.gains[a].integral_cap};
                off_kvff: next_state.rdata = 32'(state.gains[a].vel_feedforward_gain);
                off_kacc: next_state.rdata = 32'(state.gains[a].accel_feedforward_gain);
                off_demand_pos: next_state.rdata = state.demand_pos[a];
                off_status: next_state.rdata = {24'h0, state.fixed_pct[a][5:0], state.mode[a]};
                off_output: next_state.rdata = {{16{demand[a][15]}}, demand[a]};
                off_ferr: next_state.rdata = ferr[a];
                default:
                begin
                    next_state.rdata = '0;
                    next_state.rresp = resp_slverr;
                end
            endcase
        end
        else if (state.rvalid && rready)
            next_state.rvalid = 1'b0;
    end

    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state <= '0;
            state.period <= period_default;
        end
        else
            state <= next_state;
    end

    assign awready = !state.aw_held;
    assign wready = !state.w_held;
    assign arready = !state.rvalid;
    assign bvalid = state.bvalid;
    assign bresp = state.bresp;
    assign rvalid = state.rvalid;
    assign rdata = state.rdata;
    assign rresp = state.rresp;
    assign servo_tick_out = state.tick;

    sequence tick_seen;
        state.tick;
    endsequence
    sequence quiet_until_next;
        !state.tick [*1] ##0 1'b1;
    endsequence
    tick_spacing_a: assert property (@(posedge clk_in) disable iff (reset_in)
        tick_seen ##1 (state.period > 32'h1) |-> quiet_until_next)
        else $error("servo ticks too close");
    halt_cmd_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state.aw_held && state.w_held && !state.bvalid && state.aw_addr == off_cmd
        && state.w_data[cmd_op_lsb +: 2] == op_halt
        |=> state.mode[state.w_data[cmd_axis_lsb +: ax_w]] == mode_halt)
        else $error("halt command not applied to named axis");
endmodule

// >>> bench/servo_plant_model.sv
// bench partner: drive amplifier and encoder seen as a motor position counter
`timescale 1ns/1ps
module servo_plant_model
#(
    parameter int unsigned axes = 4
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // loop side
    input wire logic tick_in,
    input wire logic signed [31:0] rate_in,
    // encoder words, same count on every axis
    output logic [axes*32-1:0] measured_pos_out
);
    logic signed [31:0] pos;
    // shaft turns at a set rate per tick; amplifier loop left open so terms stay predictable
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            pos <= 32'sh0;
        else if (tick_in)
            pos <= pos + rate_in;
    end
    assign measured_pos_out = {axes{pos}};
endmodule

// >>> bench/tb_top.sv
// testbench: register-driven scenarios for the servo position loop
`timescale 1ns/1ps
module tb_top;
    import servo_pkg::*;
    localparam int unsigned axes = 4;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, tick;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [axes*32-1:0] meas;
    logic [axes*16-1:0] outs;
    logic signed [31:0] rate;
    int errors = 0;
    int cmp_count = 0;
    int n;

    initial
    begin
        forever #12.5 clk_in = ~clk_in;
    end

    servo_position_loop #(.axes(axes), .period_default(32'h8)) i_servo_position_loop (
        .clk_in(clk_in), .reset_in(reset_in),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .measured_pos_in(meas), .axis_output_out(outs), .servo_tick_out(tick));

    servo_plant_model #(.axes(axes)) i_servo_plant_model (
        .clk_in(clk_in), .reset_in(reset_in), .tick_in(tick), .rate_in(rate), .measured_pos_out(meas));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] ch(input int g);
        return {16'h0, outs[g*16+:16]};
    endfunction

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task rd_reg(input logic [7:0] a);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_in);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // returns two edges after the tick is seen, two cycles after the output has landed on that edge
    task wait_tick(input int k);
        repeat (k)
        begin
            do @(posedge clk_in); while (tick !== 1'b1);
        end
        repeat (2) @(posedge clk_in);
    endtask

    task period_is(input logic [31:0] exp);
        do @(posedge clk_in); while (tick !== 1'b1);
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (tick !== 1'b1 && n < 100);
        check(32'(n), exp);
    endtask

    // one gain alone at unity, all others zeroed, then a demand step after a settled history
    task term(input logic [7:0] g, input logic signed [31:0] r, input logic [31:0] step, input logic [31:0] exp);
        for (int a = 8; a <= 32; a += 4)
            wr(8'(a), 32'h0);
        wr(off_demand_pos, 32'h0);
        rate <= r;
        wr(off_cmd, 32'h0000_0300);
        wait_tick(3);
        wr(g, 32'h0000_0100);
        wait_tick(1);
        wr(off_demand_pos, step);
        wait_tick(1);
        check(ch(0), exp);
    endtask

    task finish_test;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        rate = 32'sh0;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        check(outs[31:0], 32'h0);
        rd_reg(off_status);
        check({30'h0, rd[1:0]}, 32'h0);
        wr(off_cmd, 32'h0000_0105);
        wait_tick(1);
        check(ch(0), 32'h0666);
        check(ch(1), 32'h0);
        wr(off_cmd, 32'h0000_01fb);
        wait_tick(1);
        check(ch(0), 32'hf99a);
        rd_reg(off_output);
        check(rd, 32'hffff_f99a);
        wr(off_cmd, 32'h0002_0105);
        wait_tick(1);
        check(ch(2), 32'h0666);
        check(ch(0), 32'hf99a);
        wr(off_cmd, 32'h0000_0200);
        wr(off_cmd, 32'h0002_0200);
        wait_tick(1);
        check(ch(0), 32'h0);
        check(ch(2), 32'h0);
        // refused: no operation code, unmapped offset
        wr(off_cmd, 32'h0000_0005);
        check({30'h0, resp}, {30'h0, resp_slverr});
        rd_reg(8'h3c);
        check({30'h0, resp}, {30'h0, resp_slverr});
        check(rd, 32'h0);
        period_is(32'h8);
        wr(off_period, 32'h28);
        wait_tick(1);
        period_is(32'h28);
        wr(off_ctrl, 32'h0);
        wr(off_demand_pos, 32'h64);
        wr(off_prop_gain, 32'h0000_0100);
        wr(off_cmd, 32'h0000_0300);
        wait_tick(2);
        check(ch(0), 32'h0064);
        rd_reg(off_ferr);
        check(rd, 32'h64);
        wr(off_prop_gain, 32'h0000_7fff);
        wr(off_demand_pos, 32'h3e8);
        wait_tick(2);
        check(ch(0), 32'h7fff);
        wr(off_demand_pos, 32'hffff_fc18);
        wait_tick(2);
        check(ch(0), 32'h8001);
        wr(off_cmd, 32'h0000_0200);
        wait_tick(1);
        check(ch(0), 32'h0);
        term(off_vel_gain, 32'sd10, 32'h0, 32'hfff6);
        term(off_deriv_gain, 32'sd10, 32'h0, 32'hfff6);
        term(off_kvff, 32'sd0, 32'h32, 32'h0032);
        term(off_kacc, 32'sd0, 32'h32, 32'h0032);
        // integral alone, error held at 1000 counts so the cap must bind
        wr(off_kacc, 32'h0);
        wr(off_demand_pos, i_servo_plant_model.pos + 32'sd1000);
        wr(off_int_gain, 32'h0000_0100);
        wr(off_icap, 32'h0000_0085);
        wait_tick(20);
        check(ch(0), 32'h0666);
        wr(off_icap, 32'h0000_0005);
        wait_tick(2);
        check(ch(0), 32'h0);
        wr(off_icap, 32'h0000_0105);
        wait_tick(20);
        check(ch(0), 32'h0666);
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk_in);
        errors++;
        finish_test();
    end
endmodule
